// ### rtl/preset_counter.sv
`timescale 1ns/1ps
module preset_counter
  import preset_counter_pkg::*;
#(
  parameter int unsigned RST_CYC = RST_DELAY_CYC,
  parameter int unsigned OUT_CYC = OUT_DELAY_CYC
) (
  // Clock and reset
  input  wire logic                   clock,
  input  wire logic                   nrst,
  input  wire logic                   ce,
  // Settings
  input  wire logic [PV_WIDTH-1:0]    set_value,
  input  wire logic [PSCL_WIDTH-1:0]  prescale,
  input  wire logic                   batch_en,
  // Field inputs
  input  wire logic                   count_pulse,
  input  wire logic                   count_reset,
  // Outputs
  output logic                        ctrl_out,
  output logic [PV_WIDTH-1:0]         present_value,
  output logic [BATCH_WIDTH-1:0]      batch_count,
  output logic                        overflow
);

  // ==========================================================================
  // State
  // ==========================================================================
  logic [PV_WIDTH-1:0]    pv_q;        // Present value
  logic [PV_WIDTH-1:0]    pv_d;        // Next present value
  logic [BATCH_WIDTH-1:0] batch_q;     // Batch count
  logic                   ovf_q;       // Overflow latched
  logic                   pulse_q;     // Previous pulse level
  logic                   out_q;       // Output register
  logic                   hit_q;       // Match already counted

  // ==========================================================================
  // Decode
  // ==========================================================================
  logic                   edge_w;      // Rising count edge
  logic [PV_WIDTH:0]      sum_w;       // Present value plus prescale
  logic                   wrap_w;      // Addition overflows
  logic                   match_w;     // Comparison true
  logic                   want_on;     // Output should be on
  logic                   on_done;     // On delay elapsed
  logic                   off_done;    // Off delay elapsed

  assign edge_w  = count_pulse && !pulse_q && !count_reset;
  assign sum_w   = {1'b0, pv_q} + {{(PV_WIDTH + 1 - PSCL_WIDTH){1'b0}}, prescale};
  assign wrap_w  = sum_w[PV_WIDTH];
  assign pv_d    = wrap_w ? PV_MAX : sum_w[PV_WIDTH-1:0];
  // Live compare, zero case included since 0 >= 0
  assign match_w = (pv_q >= set_value);
  assign want_on = (match_w || ovf_q) && !count_reset;

  // ==========================================================================
  // Delays
  // ==========================================================================
  delay_line #(.LEN(OUT_CYC)) u_on_dly (
    .clock (clock),
    .nrst  (nrst),
    .ce    (ce),
    .start (want_on),
    .done  (on_done)
  );

  delay_line #(.LEN(RST_CYC)) u_off_dly (
    .clock (clock),
    .nrst  (nrst),
    .ce    (ce),
    .start (count_reset),
    .done  (off_done)
  );

  // Counting
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pv_q    <= PV_RESET;
      ovf_q   <= 1'b0;
      pulse_q <= 1'b0;
    end else if (ce) begin
      pulse_q <= count_pulse;
      if (count_reset) begin
        pv_q  <= PV_RESET;
        ovf_q <= 1'b0;
      end else if (edge_w && !ovf_q) begin
        pv_q  <= pv_d;
        ovf_q <= wrap_w;
      end
    end
  end

  // Batch counting, one step per match
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      batch_q <= BATCH_RESET;
      hit_q   <= 1'b0;
    end else if (ce) begin
      hit_q <= match_w && !count_reset;
      if (batch_en && match_w && !hit_q && !count_reset) begin
        batch_q <= batch_q + BATCH_WIDTH'(1);
      end
    end
  end

  // Output register
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      out_q <= 1'b0;
    end else if (ce) begin
      if (off_done || !want_on) begin
        out_q <= out_q && count_reset && !off_done;
      end else if (on_done) begin
        out_q <= 1'b1;
      end
    end
  end

  assign ctrl_out      = out_q;
  assign present_value = pv_q;
  assign batch_count   = batch_q;
  assign overflow      = ovf_q;

  // ==========================================================================
  // Checks
  // ==========================================================================
  property p_reset_off;
    @(posedge clock) disable iff (!nrst)
    (ce && count_reset && off_done) |=> !ctrl_out;
  endproperty
  a_reset_off: assert property (p_reset_off) else $error("Output on after reset");

  property p_zero_on;
    @(posedge clock) disable iff (!nrst)
    (ce && on_done && pv_q == '0 && set_value == '0 && !count_reset) |=> ctrl_out;
  endproperty
  a_zero_on: assert property (p_zero_on) else $error("Zero case missed");

  property p_ovf_hold;
    @(posedge clock) disable iff (!nrst)
    (ce && ovf_q && !count_reset) |=> ovf_q && pv_q == PV_MAX;
  endproperty
  a_ovf_hold: assert property (p_ovf_hold) else $error("Overflow lost");

  property p_batch_step;
    @(posedge clock) disable iff (!nrst)
    (ce && batch_en && match_w && !hit_q && !count_reset) |=> batch_q == $past(batch_q) + 1'b1;
  endproperty
  a_batch_step: assert property (p_batch_step) else $error("Batch step missing");

  property p_no_early_on;
    @(posedge clock) disable iff (!nrst)
    (!ctrl_out && !on_done) |=> !ctrl_out;
  endproperty
  a_no_early_on: assert property (p_no_early_on) else $error("Output early");

  property p_pv_step;
    @(posedge clock) disable iff (!nrst)
    (ce && edge_w && !ovf_q && !wrap_w) |=> pv_q == $past(pv_q) + $past(prescale);
  endproperty
  a_pv_step: assert property (p_pv_step) else $error("Prescale step wrong");

  property p_live_cmp;
    @(posedge clock) disable iff (!nrst)
    (ce && on_done && match_w && !count_reset) |=> ctrl_out;
  endproperty
  a_live_cmp: assert property (p_live_cmp) else $error("Match not shown");

  property p_reset_clears;
    @(posedge clock) disable iff (!nrst)
    (ce && count_reset) |=> pv_q == PV_RESET && !ovf_q;
  endproperty
  a_reset_clears: assert property (p_reset_clears) else $error("Reset not clearing");

  // ==========================================================================
  // Sequenced checks
  // ==========================================================================
  // Match has held through the whole on delay, no reset pending
  sequence s_on_ready;
    ce && on_done && want_on && !off_done;
  endsequence

  // Reset line high, off delay still running, output still on
  sequence s_reset_hold;
    ce && count_reset && ctrl_out && !off_done;
  endsequence

  // Output shown on the following edge
  sequence s_out_high;
    ctrl_out;
  endsequence

  // Once the on delay has run out the output must follow
  property p_on_step;
    @(posedge clock) disable iff (!nrst)
    s_on_ready |=> s_out_high;
  endproperty
  a_on_step: assert property (p_on_step) else $error("Output not raised after delay");

  // A short reset must not drop the output before the off delay ends
  property p_off_delay;
    @(posedge clock) disable iff (!nrst)
    s_reset_hold |=> s_out_high;
  endproperty
  a_off_delay: assert property (p_off_delay) else $error("Output dropped too early");

  // A live compare that no longer holds drops the output at once
  property p_drop_off;
    @(posedge clock) disable iff (!nrst)
    (ce && !want_on && !count_reset) |=> !ctrl_out;
  endproperty
  a_drop_off: assert property (p_drop_off) else $error("Output kept without match");

  // Batch count stays put outside batch mode
  property p_batch_idle;
    @(posedge clock) disable iff (!nrst)
    (ce && !batch_en) |=> $stable(batch_q);
  endproperty
  a_batch_idle: assert property (p_batch_idle) else $error("Batch moved while off");

  // Clock enable low freezes counting and the output
  property p_freeze;
    @(posedge clock) disable iff (!nrst)
    (!ce) |=> $stable(pv_q) && $stable(batch_q) && $stable(out_q);
  endproperty
  a_freeze: assert property (p_freeze) else $error("State moved while frozen");
endmodule

// ### rtl/preset_counter_pkg.sv
package preset_counter_pkg;

  // ==========================================================================
  // Counter geometry
  // ==========================================================================
  localparam int unsigned PV_WIDTH     = 24;        // Present value width
  localparam int unsigned BATCH_WIDTH  = 16;        // Batch count width
  localparam int unsigned PSCL_WIDTH   = 16;        // Prescale step width
  localparam logic [23:0] PV_MAX       = 24'hFFFFFF; // Overflow reading
  localparam logic [23:0] PV_RESET     = 24'h000000; // Present value at reset
  localparam logic [15:0] BATCH_RESET  = 16'h0000;   // Batch count at reset

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int unsigned CLOCK_HZ        = 50000000; // Sampling clock rate
  localparam int unsigned RST_DELAY_US    = 1000;     // Reset to output off
  localparam int unsigned RST_DELAY_CYC   = (CLOCK_HZ / 1000000) * RST_DELAY_US;
  localparam int unsigned OUT_DELAY_US    = 200;      // Match to output on
  localparam int unsigned OUT_DELAY_CYC   = (CLOCK_HZ / 1000000) * OUT_DELAY_US;

endpackage

// ### rtl/delay_line.sv
`timescale 1ns/1ps
// ============================================================================
// Delay counter: done rises after start held high for LEN cycles
// ============================================================================
module delay_line #(
  parameter int unsigned LEN = 16
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic nrst,
  input  wire logic ce,
  // Control
  input  wire logic start,
  output logic      done
);
  localparam int unsigned CW = $clog2(LEN + 1);

  logic [CW-1:0] cnt_q;     // Cycles start has been high
  logic [CW-1:0] cnt_d;     // Next count
  logic          at_end;    // Count reached length

  assign at_end = (cnt_q == CW'(LEN));
  assign cnt_d  = !start ? '0 : (at_end ? cnt_q : cnt_q + CW'(1));
  assign done   = at_end;

  // Count while start holds
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= '0;
    end else if (ce) begin
      cnt_q <= cnt_d;
    end
  end
endmodule

// ### bench/field_source.sv
`timescale 1ns/1ps
// ==========================================
// Field side: pulse source and reset line
// ==========================================
module field_source (
  // Clock
  input  wire logic clock,
  // Field lines
  output logic      count_pulse,
  output logic      count_reset
);
  // Both lines idle low from time zero
  initial begin
    count_pulse = 1'b0;
    count_reset = 1'b0;
  end
  // Each pulse gets one high and one low sample
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge clock) #2 count_pulse = 1'b1;
      @(posedge clock) #2 count_pulse = 1'b0;
    end
  endtask
  // Reset line level, changed just after an edge
  task automatic set_reset(input logic v);
    @(posedge clock) #2 count_reset = v;
  endtask
endmodule

// ### bench/tb_preset_counter.sv
`timescale 1ns/1ps
// ==========================================
// Bench for the preset counter
// ==========================================
module tb_preset_counter;
  import preset_counter_pkg::*;
  localparam int unsigned OUT_N = 4;   // Shortened output delay
  localparam int unsigned RST_N = 8;   // Shortened reset delay
  logic                   clock, nrst, ce, batch_en, count_pulse, count_reset;
  logic                   ctrl_out, overflow;
  logic [PV_WIDTH-1:0]    set_value, present_value;
  logic [PSCL_WIDTH-1:0]  prescale;
  logic [BATCH_WIDTH-1:0] batch_count;
  int                     errors, n_tests;
  preset_counter #(.RST_CYC(RST_N), .OUT_CYC(OUT_N)) dut (
    .clock(clock), .nrst(nrst), .ce(ce), .set_value(set_value),
    .prescale(prescale), .batch_en(batch_en), .count_pulse(count_pulse),
    .count_reset(count_reset), .ctrl_out(ctrl_out),
    .present_value(present_value), .batch_count(batch_count),
    .overflow(overflow));
  field_source src (.clock(clock), .count_pulse(count_pulse),
    .count_reset(count_reset));
  // 50 MHz clock
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // Compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %0h exp %0h", $time, got, exp);
    end
  endtask
  // Bounded wait for the output level, then compare
  task automatic wait_out(input logic v);
    for (int i = 0; i < OUT_N + 4 && ctrl_out !== v; i++) begin
      @(posedge clock);
      #1;
    end
    #1 check(ctrl_out, v);
  endtask
  // Device reset for 20 cycles with new settings
  task automatic do_reset(input logic [23:0] sv, input logic [15:0] ps);
    @(posedge clock) #2 nrst = 1'b0;
    set_value = sv;
    prescale = ps;
    repeat (20) @(posedge clock);
    #2 nrst = 1'b1;
  endtask
  // Zero set and zero value turn output on; reset turns it off
  task automatic run_zero();
    do_reset(24'h000000, 16'h0001);
    wait_out(1'b1);
    src.set_reset(1'b1);
    repeat (RST_N) @(posedge clock);
    #1 check(ctrl_out, 1'b1);
    @(posedge clock);
    #1 check(ctrl_out, 1'b0);
    src.set_reset(1'b0);
  endtask
  // Prescaled steps, passing the set value, batch count
  task automatic run_prescale();
    do_reset(24'h00000A, 16'h0003);
    batch_en = 1'b1;
    src.pulse(3);
    repeat (OUT_N + 4) @(posedge clock);
    #1 check(present_value, 24'h000009);
    check(ctrl_out, 1'b0);
    src.pulse(1);
    #1 check(present_value, 24'h00000C);
    wait_out(1'b1);
    check(batch_count, 16'h0001);
  endtask
  // Set value moved onto the present value during operation
  task automatic run_live();
    do_reset(24'h000064, 16'h0003);
    src.pulse(1);
    repeat (OUT_N + 4) @(posedge clock);
    #1 check(ctrl_out, 1'b0);
    @(posedge clock) #2 set_value = 24'h000003;
    wait_out(1'b1);
  endtask
  // Set at PV_MAX; overflow saturates onto it and turns output on
  task automatic run_overflow();
    do_reset(24'hFFFFFF, 16'hFFFF);
    src.pulse(256);
    #1 check(present_value, 24'hFFFF00);
    check(overflow, 1'b0);
    src.pulse(1);
    #1 check(present_value, PV_MAX);
    check(overflow, 1'b1);
    wait_out(1'b1);
  endtask
  // Frozen by the clock enable, then slow counting without batch mode
  task automatic run_hold();
    do_reset(24'h000006, 16'h0002);
    ce = 1'b0;
    batch_en = 1'b0;
    src.pulse(2);
    repeat (OUT_N + 4) @(posedge clock);
    #1 check(present_value, 24'h000000);
    @(posedge clock) #2 ce = 1'b1;
    src.pulse(1);
    repeat (20) @(posedge clock);
    #1 check(present_value, 24'h000002);
    src.pulse(2);
    repeat (OUT_N) @(posedge clock);
    #1 check(ctrl_out, 1'b0);
    @(posedge clock);
    #1 check(ctrl_out, 1'b1);
    check(batch_count, 16'h0000);
  endtask
  // Counts, verdict, end of run
  task automatic print_verdict();
    $display("errors %0d comparisons %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Main sequence
  initial begin
    errors = 0;
    n_tests = 0;
    nrst = 1'b0;
    ce = 1'b1;
    batch_en = 1'b0;
    set_value = 24'h000000;
    prescale = 16'h0001;
    run_zero();
    run_prescale();
    run_live();
    run_overflow();
    run_hold();
    print_verdict();
  end
  // Watchdog, far beyond the expected run time
  initial begin
    #200000;
    errors++;
    print_verdict();
  end
endmodule
